// File: logic/usb_control_status_regs.sv
`include "usb_csr_map.svh"
`default_nettype none
module usb_control_status_regs #(
	parameter int FIFO_DEPTH = 4,
	parameter int FRAME_CYC = `FRAME_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// ----------------------------------------
	// packet engine side
	// ----------------------------------------
	input wire logic [7:0] err_flags_i,
	input wire logic xfer_push_i,
	input wire logic [3:0] xfer_endpoint_i,
	input wire logic xfer_tx_i,
	input wire logic xfer_odd_i,
	input wire logic setup_rx_i,
	input wire logic token_busy_i,
	input wire logic line_j_i,
	input wire logic line_se0_i,
	input wire logic trn_flag_clear_i,
	output logic usb_top_irq_o,
	output logic transaction_done_flag_o,
	output logic xfer_fifo_full_o,
	output logic packet_processing_hold_o,
	output logic bus_reset_drive_o,
	output logic host_logic_reset_o,
	output logic resume_drive_o,
	output logic ls_eop_drive_o,
	output logic pingpong_pointer_reset_o,
	output logic module_enable_o,
	output logic frame_start_o
);
	localparam int EOP_CYC = `LS_EOP_CYC;
	// ----------------------------------------
	// registers
	// ----------------------------------------
	logic [7:0] err_mask, next_err_mask;
	logic [7:0] irq_en, next_irq_en;
	logic hold, next_hold;
	logic busrst, next_busrst;
	logic host_enable, next_host_enable;
	logic resume, next_resume;
	logic enable, next_enable;
	logic pprst, next_pprst;
	logic hostrst, next_hostrst;
	logic ack, next_ack;
	logic [31:0] rdat, next_rdat;
	logic irq, next_irq;
	logic req, wr_acc;
	logic [7:0] ctrl_view;
	usb_csr_pkg::xfer_rec_t head;
	logic head_valid, fifo_full, tick;
	// byte lane 0 holds every implemented bit
	function automatic logic lane0_write(input logic [3:0] adr, input logic [3:0] ofs,
			input logic we, input logic [3:0] sel);
		lane0_write = we && sel[0] && (adr == ofs);
	endfunction
	// one new request per bus cycle: ack drops before the next is taken
	assign req = wb_cyc_i && wb_stb_i && !ack;
	assign wr_acc = req && wb_we_i;
	// host view of bit 5 is the live busy line
	// live line states
	always_comb begin
		ctrl_view = 8'h00;
		ctrl_view[`C_JSTATE] = line_j_i;
		ctrl_view[`C_SE0] = line_se0_i;
		ctrl_view[`C_HOLD] = host_enable ? token_busy_i : hold;
		ctrl_view[`C_BUSRST] = busrst;
		ctrl_view[`C_HOST_ENABLE] = host_enable;
		ctrl_view[`C_RESUME] = resume;
		ctrl_view[`C_PPRST] = pprst;
		ctrl_view[`C_ENABLE] = enable;
	end
	// se0 shown live in ctrl_view above
	// register writes and read mux
	always_comb begin
		next_err_mask = err_mask;
		next_irq_en = irq_en;
		next_hold = hold;
		next_busrst = busrst;
		next_host_enable = host_enable;
		next_resume = resume;
		next_enable = enable;
		next_pprst = 1'b0;
		next_hostrst = 1'b0;
		next_ack = req;
		next_rdat = 32'h0;
		if (wr_acc && lane0_write(wb_adr_i, `ERR_MASK_OFS, wb_we_i, wb_sel_i)) begin
			next_err_mask = wb_dat_i[7:0];
		end
		if (wr_acc && lane0_write(wb_adr_i, `IRQ_EN_OFS, wb_we_i, wb_sel_i)) begin
			next_irq_en = wb_dat_i[7:0];
		end
		if (wr_acc && lane0_write(wb_adr_i, `MOD_CTRL_OFS, wb_we_i, wb_sel_i)) begin
			next_hold = wb_dat_i[`C_HOLD];
			next_busrst = wb_dat_i[`C_BUSRST];
			next_host_enable = wb_dat_i[`C_HOST_ENABLE];
			next_resume = wb_dat_i[`C_RESUME];
			next_enable = wb_dat_i[`C_ENABLE];
			next_pprst = wb_dat_i[`C_PPRST];
			next_hostrst = (wb_dat_i[`C_HOST_ENABLE] != host_enable);
		end
		// setup sets hold, beats a clearing write
		if (setup_rx_i && !host_enable) begin
			next_hold = 1'b1;
		end
		if (req && !wb_we_i) begin
			case (wb_adr_i)
				`ERR_MASK_OFS: next_rdat = {24'h0, err_mask};
				`XFER_STAT_OFS: next_rdat = {24'h0, head, 2'b00};
				`MOD_CTRL_OFS: next_rdat = {24'h0, ctrl_view};
				`IRQ_EN_OFS: next_rdat = {24'h0, irq_en};
				default: next_rdat = 32'h0;
			endcase
		end
		next_irq = ((err_flags_i & err_mask) != 8'h00) && irq_en[`IRQ_EN_ERR_BIT];
	end
	// bit 1 covers token crc or frame end by mode
	// register stage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			err_mask <= `ERR_MASK_RST;
			irq_en <= `IRQ_EN_RST;
			hold <= 1'b0;
			busrst <= 1'b0;
			host_enable <= 1'b0;
			resume <= 1'b0;
			enable <= 1'b0;
			pprst <= 1'b0;
			hostrst <= 1'b0;
			ack <= 1'b0;
			rdat <= 32'h0;
			irq <= 1'b0;
		end else begin
			err_mask <= next_err_mask;
			irq_en <= next_irq_en;
			hold <= next_hold;
			busrst <= next_busrst;
			host_enable <= next_host_enable;
			resume <= next_resume;
			enable <= next_enable;
			pprst <= next_pprst;
			hostrst <= next_hostrst;
			ack <= next_ack;
			rdat <= next_rdat;
			irq <= next_irq;
		end
	end
	// ----------------------------------------
	// transaction record queue
	// ----------------------------------------
	// head visible, valid while records queued
	xfer_record_fifo #(
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.push_i(xfer_push_i),
		.rec_i({xfer_endpoint_i, xfer_tx_i, xfer_odd_i}),
		.pop_i(trn_flag_clear_i),
		.head_o(head),
		.valid_o(head_valid),
		.full_o(fifo_full)
	);
	// direction and bank packed into rec_i above
	// ----------------------------------------
	// resume sequencer
	// ----------------------------------------
	usb_csr_pkg::resume_state_t rs, next_rs;
	logic [15:0] eop_cnt, next_eop_cnt;
	always_comb begin
		next_rs = rs;
		next_eop_cnt = 16'h0;
		case (rs)
			usb_csr_pkg::RES_IDLE: if (next_resume) next_rs = usb_csr_pkg::RES_DRIVE;
			usb_csr_pkg::RES_DRIVE: begin
				if (!next_resume) next_rs = host_enable ? usb_csr_pkg::RES_EOP : usb_csr_pkg::RES_IDLE;
			end
			usb_csr_pkg::RES_EOP: begin
				next_eop_cnt = eop_cnt + 16'h1;
				if (eop_cnt == 16'(EOP_CYC - 1)) next_rs = usb_csr_pkg::RES_IDLE;
			end
			default: next_rs = usb_csr_pkg::RES_IDLE;
		endcase
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rs <= usb_csr_pkg::RES_IDLE;
			eop_cnt <= 16'h0;
		end else begin
			rs <= next_rs;
			eop_cnt <= next_eop_cnt;
		end
	end
	// ----------------------------------------
	// frame start timer
	// ----------------------------------------
	// frame start every 1 ms in host mode
	frame_tick #(
		.FRAME_CYC(FRAME_CYC)
	) u_tick (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.run_i(host_enable && enable && !hostrst),
		.tick_o(tick)
	);
	// ----------------------------------------
	// output stage
	// ----------------------------------------
	// module enable in device mode
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			usb_top_irq_o <= 1'b0;
			transaction_done_flag_o <= 1'b0;
			xfer_fifo_full_o <= 1'b0;
			packet_processing_hold_o <= 1'b0;
			bus_reset_drive_o <= 1'b0;
			host_logic_reset_o <= 1'b0;
			resume_drive_o <= 1'b0;
			ls_eop_drive_o <= 1'b0;
			pingpong_pointer_reset_o <= 1'b0;
			module_enable_o <= 1'b0;
			frame_start_o <= 1'b0;
		end else begin
			usb_top_irq_o <= irq;
			transaction_done_flag_o <= head_valid;
			xfer_fifo_full_o <= fifo_full;
			packet_processing_hold_o <= hold && !host_enable;
			bus_reset_drive_o <= busrst && host_enable;
			host_logic_reset_o <= hostrst;
			resume_drive_o <= (rs == usb_csr_pkg::RES_DRIVE);
			ls_eop_drive_o <= (rs == usb_csr_pkg::RES_EOP);
			pingpong_pointer_reset_o <= pprst;
			module_enable_o <= enable && !host_enable;
			frame_start_o <= tick;
		end
	end
	assign wb_ack_o = ack;
	assign wb_dat_o = rdat;
	// ----------------------------------------
	// checks
	// ----------------------------------------
	sequence setup_seen;
		setup_rx_i && !host_enable;
	endsequence
	hold_sets_a: assert property (@(posedge clk_i) disable iff (rst_i)
		setup_seen |=> hold) else $error("setup did not set hold");
	irq_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		usb_top_irq_o |-> $past(irq_en[1], 2)) else $error("irq without enable");
	irq_fire_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(((err_flags_i & err_mask) != 8'h00) && irq_en[1]) |-> ##2 usb_top_irq_o)
		else $error("masked error lost");
	toggle_rst_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$changed(host_enable) |-> hostrst ##1 host_logic_reset_o) else $error("no host reset");
	pprst_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)
		pprst |=> !pprst || $past(wr_acc)) else $error("pointer reset stuck");
	busy_view_a: assert property (@(posedge clk_i) disable iff (rst_i)
		host_enable |-> ctrl_view[5] == token_busy_i) else $error("busy view wrong");
	eop_len_a: assert property (@(posedge clk_i) disable iff (rst_i)
		$rose(rs == usb_csr_pkg::RES_EOP) |-> (rs == usb_csr_pkg::RES_EOP) [*8])
		else $error("eop too short");
	upper_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |-> wb_dat_o[31:8] == 24'h0) else $error("upper bits not zero");
	ack_once_a: assert property (@(posedge clk_i) disable iff (rst_i)
		wb_ack_o |=> !wb_ack_o) else $error("ack held");
endmodule
`default_nettype wire

// File: logic/usb_csr_map.svh
// Overview of operation
// - eight per-error enable bits, bits 7..0
// - mask bit 1: token crc or frame end
// - error irq also needs general error enable
// - bits 31..8 and status 1..0 read zero
// - status 7..4 give last endpoint number
// - status bit 3: one means transmit
// - status bit 2: one means odd bank
// - status is head of four-entry record fifo
// - clearing transaction-done flag pops the fifo
// - control bit 7 shows live J state
// - control bit 6 shows live SE0
// - device: setup token sets bit 5, holds processing
// - host: bit 5 reads token in progress
// - host: bit 4 drives bus reset
// - bit 3 host enable; toggle resets host logic
// - bit 2 drives resume signalling while set
// - host: resume clear appends low-speed EOP
// - writing bit 1 resets ping-pong pointers even
// - device: bit 0 enables module
// - host: bit 0 sends frame start every 1 ms
`ifndef USB_CSR_MAP_SVH
`define USB_CSR_MAP_SVH
// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define ERR_MASK_OFS 4'h0
`define XFER_STAT_OFS 4'h4
`define MOD_CTRL_OFS 4'h8
`define IRQ_EN_OFS 4'hC
// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define IRQ_EN_ERR_BIT 1
`define IRQ_EN_RST 8'h00
`define ERR_MASK_RST 8'h00
`define CTRL_RST 6'h00
`define C_JSTATE 7
`define C_SE0 6
`define C_HOLD 5
`define C_BUSRST 4
`define C_HOST_ENABLE 3
`define C_RESUME 2
`define C_PPRST 1
`define C_ENABLE 0
// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_MHZ 100
`define FRAME_US 1000
`define FRAME_CYC (`FRAME_US * `CLK_MHZ)
`define LS_EOP_NS 1330
`define LS_EOP_CYC ((`LS_EOP_NS * `CLK_MHZ + 999) / 1000)
`endif

// File: logic/usb_csr_pkg.sv
`default_nettype none
package usb_csr_pkg;
	typedef logic [5:0] xfer_rec_t;
	typedef enum logic [1:0] {RES_IDLE, RES_DRIVE, RES_EOP} resume_state_t;
endpackage
`default_nettype wire

// File: logic/xfer_record_fifo.sv
`include "usb_csr_map.svh"
`default_nettype none
// ----------------------------------------
// transaction record queue
// ----------------------------------------
module xfer_record_fifo #(
	parameter int DEPTH = 4
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic push_i,
	input wire usb_csr_pkg::xfer_rec_t rec_i,
	input wire logic pop_i,
	output usb_csr_pkg::xfer_rec_t head_o,
	output logic valid_o,
	output logic full_o
);
	localparam int AW = $clog2(DEPTH);
	initial begin
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) $error("depth must be power of two");
	end
	usb_csr_pkg::xfer_rec_t mem [DEPTH];
	logic [AW-1:0] rd, wr, next_rd, next_wr;
	logic [AW:0] cnt, next_cnt;
	logic do_push, do_pop;
	// a push into a full queue is dropped; the engine must stall instead
	always_comb begin
		do_push = push_i && (cnt != (AW+1)'(DEPTH));
		do_pop = pop_i && (cnt != '0);
		next_wr = do_push ? wr + 1'b1 : wr;
		next_rd = do_pop ? rd + 1'b1 : rd;
		next_cnt = cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
	end
	// pointers and storage
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rd <= '0;
			wr <= '0;
			cnt <= '0;
		end else begin
			rd <= next_rd;
			wr <= next_wr;
			cnt <= next_cnt;
		end
		if (do_push) mem[wr] <= rec_i;
	end
	assign head_o = mem[rd];
	assign valid_o = (cnt != '0);
	assign full_o = (cnt == (AW+1)'(DEPTH));
endmodule
`default_nettype wire

// File: logic/frame_tick.sv
`include "usb_csr_map.svh"
`default_nettype none
// ----------------------------------------
// frame start timer
// ----------------------------------------
module frame_tick #(
	parameter int FRAME_CYC = `FRAME_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	output logic tick_o
);
	initial begin
		if (FRAME_CYC < 2) $error("frame count too small");
	end
	logic [31:0] cnt, next_cnt;
	logic next_tick;
	// count restarts whenever generation is off so the first frame is full length
	always_comb begin
		next_tick = 1'b0;
		next_cnt = 32'h0;
		if (run_i) begin
			if (cnt == 32'(FRAME_CYC - 1)) begin
				next_tick = 1'b1;
			end else begin
				next_cnt = cnt + 32'h1;
			end
		end
	end
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cnt <= 32'h0;
			tick_o <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick_o <= next_tick;
		end
	end
endmodule
`default_nettype wire

// File: verification/usb_engine_model.sv
`default_nettype none
// ----
// packet engine and bus line model
// ----
module usb_engine_model (
	input wire logic clk_i,
	output logic [7:0] err_flags_o,
	output logic push_o,
	output logic [3:0] ep_o,
	output logic tx_o,
	output logic odd_o,
	output logic setup_o,
	output logic busy_o,
	output logic j_o,
	output logic se0_o,
	output logic pop_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{err_flags_o, push_o, ep_o, tx_o, odd_o, setup_o, busy_o, j_o, se0_o, pop_o} = '0;
	end
	// levels are changed just after an edge, as the engine would
	task automatic levels(input logic [7:0] err, input logic busy, j, se0);
		err_flags_o <= err;
		busy_o <= busy;
		j_o <= j;
		se0_o <= se0;
	endtask
	// record data only means something with the strobe, so it is scrambled after
	task automatic push(input logic [3:0] ep, input logic tx, odd);
		push_o <= 1'b1;
		ep_o <= ep;
		tx_o <= tx;
		odd_o <= odd;
		@(posedge clk_i);
		push_o <= 1'b0;
		ep_o <= ~ep;
		tx_o <= ~tx;
		odd_o <= ~odd;
		@(posedge clk_i);
	endtask
	task automatic setup();
		setup_o <= 1'b1;
		@(posedge clk_i);
		setup_o <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic pop();
		pop_o <= 1'b1;
		@(posedge clk_i);
		pop_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule
`default_nettype wire

// File: verification/tb.sv
`include "usb_csr_map.svh"
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int FRAME = 50;
	logic clk_i = 1'b0;
	logic rst_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
	logic [3:0] wb_adr_i, wb_sel_i, ep;
	logic [31:0] wb_dat_i, wb_dat_o, rd_v;
	logic irq, done, full, hold, busrst, hrst, resume, lseop, pprst, men, sof;
	logic push, tx, odd, setup, busy, lj, lse0, pop;
	logic [7:0] err;
	usb_csr_pkg::xfer_rec_t recs [5] = '{6'h3F, 6'h00, 6'h2A, 6'h15, 6'h0F};
	int err_total = 0;
	int samples_checked = 0;
	int hrst_cnt = 0;
	int pp_cnt = 0;
	int sof_cnt = 0;
	int n;
	always #5 clk_i = ~clk_i;
	usb_engine_model eng (.clk_i(clk_i), .err_flags_o(err), .push_o(push), .ep_o(ep), .tx_o(tx),
		.odd_o(odd), .setup_o(setup), .busy_o(busy), .j_o(lj), .se0_o(lse0), .pop_o(pop));
	usb_control_status_regs #(.FIFO_DEPTH(4), .FRAME_CYC(FRAME)) dut (.clk_i(clk_i),
		.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
		.wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
		.wb_ack_o(wb_ack_o), .err_flags_i(err), .xfer_push_i(push), .xfer_endpoint_i(ep),
		.xfer_tx_i(tx), .xfer_odd_i(odd), .setup_rx_i(setup), .token_busy_i(busy),
		.line_j_i(lj), .line_se0_i(lse0), .trn_flag_clear_i(pop), .usb_top_irq_o(irq),
		.transaction_done_flag_o(done), .xfer_fifo_full_o(full),
		.packet_processing_hold_o(hold), .bus_reset_drive_o(busrst),
		.host_logic_reset_o(hrst), .resume_drive_o(resume), .ls_eop_drive_o(lseop),
		.pingpong_pointer_reset_o(pprst), .module_enable_o(men), .frame_start_o(sof));
	// pulses are counted so a stuck or doubled pulse shows up
	always @(posedge clk_i) begin
		hrst_cnt <= hrst_cnt + int'(hrst === 1'b1);
		pp_cnt <= pp_cnt + int'(pprst === 1'b1);
		sof_cnt <= sof_cnt + int'(sof === 1'b1);
	end
	// ----
	// bus tasks and checks
	// ----
	task automatic chk(input string name, input logic [31:0] exp, got);
		samples_checked++;
		if (got !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic tick(input int k);
		repeat (k) @(posedge clk_i);
	endtask
	// request held until ack is sampled, then one idle cycle
	task automatic bus(input logic we, input logic [3:0] adr, sel, input logic [31:0] wd);
		int w;
		w = 0;
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i <= we;
		wb_adr_i <= adr;
		wb_sel_i <= sel;
		wb_dat_i <= wd;
		do begin
			@(posedge clk_i);
			w++;
		end while (wb_ack_o !== 1'b1 && w < 40);
		if (wb_ack_o !== 1'b1)
			err_total++;
		rd_v = wb_dat_o;
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic wr(input logic [3:0] adr, input logic [31:0] wd);
		bus(1'b1, adr, 4'hF, wd);
	endtask
	task automatic rdc(input string name, input logic [3:0] adr, input logic [31:0] exp);
		bus(1'b0, adr, 4'hF, 32'h0);
		chk(name, exp, rd_v);
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	// ----
	// tests
	// ----
	initial begin
		rst_i = 1'b1;
		wb_cyc_i = 1'b0;
		wb_stb_i = 1'b0;
		wb_we_i = 1'b0;
		wb_adr_i = 4'h0;
		wb_sel_i = 4'h0;
		wb_dat_i = 32'h0;
		tick(12);
		rst_i <= 1'b0;
		rdc("mask", 4'h0, 32'h0);
		rdc("ctrl", 4'h8, 32'h0);
		rdc("unmapped", 4'h6, 32'h0);
		wr(4'h0, 32'hFFFFFFFF);
		rdc("mask", 4'h0, 32'hFF);
		bus(1'b1, 4'h0, 4'hE, 32'h0);
		rdc("mask no sel", 4'h0, 32'hFF);
		$display("test reset and mask done");
		wr(4'hC, 32'h2);
		for (int i = 0; i < 8; i++) begin
			wr(4'h0, 32'h1 << i);
			eng.levels(8'h01 << i, 1'b0, 1'b0, 1'b0);
			tick(4);
			chk("irq enabled", 32'h1, irq);
			eng.levels(~(8'h01 << i), 1'b0, 1'b0, 1'b0);
			tick(4);
			chk("irq masked", 32'h0, irq);
		end
		wr(4'h0, 32'hFF);
		eng.levels(8'h80, 1'b0, 1'b0, 1'b0);
		wr(4'hC, 32'h0);
		tick(4);
		chk("irq gated", 32'h0, irq);
		wr(4'hC, 32'h2);
		tick(4);
		chk("irq ungated", 32'h1, irq);
		eng.levels(8'h00, 1'b0, 1'b0, 1'b0);
		$display("test interrupt done");
		// fifth record meets a full queue and is dropped
		for (int i = 0; i < 5; i++)
			eng.push(recs[i][5:2], recs[i][1], recs[i][0]);
		tick(2);
		chk("fifo full", 32'h1, full);
		for (int i = 0; i < 4; i++) begin
			chk("done flag", 32'h1, done);
			rdc("status", 4'h4, {24'h0, recs[i], 2'b00});
			eng.pop();
			tick(2);
		end
		chk("done empty", 32'h0, done);
		$display("test fifo done");
		eng.levels(8'h00, 1'b0, 1'b1, 1'b0);
		tick(2);
		rdc("ctrl j", 4'h8, 32'h80);
		eng.levels(8'h00, 1'b1, 1'b0, 1'b1);
		tick(2);
		rdc("ctrl se0", 4'h8, 32'h40);
		eng.levels(8'h00, 1'b0, 1'b0, 1'b0);
		eng.setup();
		tick(2);
		chk("hold", 32'h1, hold);
		rdc("ctrl hold", 4'h8, 32'h20);
		wr(4'h8, 32'h15);
		tick(2);
		chk("hold off", 32'h0, hold);
		chk("enable", 32'h1, men);
		chk("reset device", 32'h0, busrst);
		chk("resume", 32'h1, resume);
		n = pp_cnt;
		wr(4'h8, 32'h03);
		tick(2);
		chk("resume off", 32'h0, resume);
		chk("no eop", 32'h0, lseop);
		chk("pingpong", 32'h1, pp_cnt - n);
		rdc("ctrl en", 4'h8, 32'h01);
		$display("test device done");
		n = hrst_cnt;
		wr(4'h8, 32'h08);
		tick(2);
		chk("host reset", 32'h1, hrst_cnt - n);
		chk("enable host", 32'h0, men);
		eng.levels(8'h02, 1'b1, 1'b0, 1'b0);
		wr(4'h0, 32'h02);
		tick(4);
		rdc("ctrl busy", 4'h8, 32'h28);
		chk("irq eof", 32'h1, irq);
		eng.levels(8'h00, 1'b0, 1'b0, 1'b0);
		tick(2);
		rdc("ctrl idle", 4'h8, 32'h08);
		wr(4'h8, 32'h18);
		tick(2);
		chk("bus reset", 32'h1, busrst);
		wr(4'h8, 32'h08);
		tick(2);
		chk("bus reset off", 32'h0, busrst);
		wr(4'h8, 32'h09);
		n = 0;
		while (sof !== 1'b1 && n < 100) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (sof !== 1'b1 && n < 100);
		chk("frame gap", FRAME, n);
		wr(4'h8, 32'h08);
		tick(2);
		n = sof_cnt;
		tick(120);
		chk("frame stop", 32'h0, sof_cnt - n);
		wr(4'h8, 32'h0C);
		tick(2);
		chk("host resume", 32'h1, resume);
		tick(20);
		wr(4'h8, 32'h08);
		n = 0;
		while (lseop !== 1'b1 && n < 10) begin
			@(posedge clk_i);
			n++;
		end
		n = 0;
		while (lseop === 1'b1 && n < 300) begin
			@(posedge clk_i);
			n++;
		end
		chk("eop length", `LS_EOP_CYC, n);
		chk("resume end", 32'h0, resume);
		n = hrst_cnt;
		wr(4'h8, 32'h00);
		tick(2);
		chk("host off", 32'h1, hrst_cnt - n);
		$display("test host done");
		finish_test();
	end
	// whole run is about six hundred and forty cycles, so this only ends a hang
	initial begin
		tick(20000);
		err_total++;
		finish_test();
	end
endmodule
`default_nettype wire
